// >>> hdl/bcp_pkg.sv
// constants, field layouts and types for the boost clock and phase control registers
package bcp_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // frame addresses
  localparam logic [5:0] ADDR_UNLOCK_REG = 6'h01;
  localparam logic [5:0] ADDR_CLK_PHASE  = 6'h03;
  localparam logic [5:0] ADDR_WDOG       = 6'h04;
  localparam int unsigned UNLOCK_BIT     = 1;
  localparam int unsigned WDOG_BIT       = 23;

  // layout of the clock and phase register, bit 23 down to 0
  typedef struct packed {
    logic [7:0] unused;
    logic [2:0] output_fault_filter_time;
    logic       dither_enable;
    logic [1:0] dither_deviation_sel;
    logic [1:0] dither_rate_sel;
    logic [2:0] switching_freq_sel;
    logic [1:0] phase_count_sel;
    logic [1:0] phase_disable;
    logic       parity;
  } bcp_cfg_s;

  localparam logic [2:0] FILT_DEF  = 3'h0;
  localparam logic [1:0] FDEV_DEF  = 2'h0;
  localparam logic [1:0] FMOD_DEF  = 2'h3;
  localparam logic [2:0] FREQ_DEF  = 3'h3;
  localparam logic [1:0] NPH_DEF   = 2'h0;
  localparam logic [1:0] DIS_DEF   = 2'h0;
  localparam logic [2:0] CODE_RSVD = 3'h6;

  // filter times in microseconds
  localparam int unsigned FILT_US_0 = 500;
  localparam int unsigned FILT_US_1 = 10;
  localparam int unsigned FILT_US_2 = 50;
  localparam int unsigned FILT_US_3 = 100;
  localparam int unsigned FILT_US_4 = 300;
  localparam int unsigned FILT_US_5 = 800;
  localparam int unsigned FILT_US_7 = 2000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // switching frequencies in units of 10 Hz
  localparam int unsigned FREQ_0 = 10101;
  localparam int unsigned FREQ_1 = 15152;
  localparam int unsigned FREQ_2 = 19608;
  localparam int unsigned FREQ_3 = 25641;
  localparam int unsigned FREQ_4 = 30303;
  localparam int unsigned FREQ_5 = 41667;
  localparam int unsigned FREQ_7 = 47619;
  localparam logic [7:0] PER_0 = 8'((CLK_HZ / 10) / FREQ_0);
  localparam logic [7:0] PER_1 = 8'((CLK_HZ / 10) / FREQ_1);
  localparam logic [7:0] PER_2 = 8'((CLK_HZ / 10) / FREQ_2);
  localparam logic [7:0] PER_3 = 8'((CLK_HZ / 10) / FREQ_3);
  localparam logic [7:0] PER_4 = 8'((CLK_HZ / 10) / FREQ_4);
  localparam logic [7:0] PER_5 = 8'((CLK_HZ / 10) / FREQ_5);
  localparam logic [7:0] PER_7 = 8'((CLK_HZ / 10) / FREQ_7);

  // dither: deviation step in percent, slowest modulation rate in units of 10 Hz
  localparam int unsigned DEV_STEP_PCT = 5;
  localparam int unsigned PCT_FULL     = 100;
  localparam int unsigned MOD_SLOW     = 195;
  localparam int unsigned MOD_SLOW_CYC = (CLK_HZ / 10) / MOD_SLOW;
  localparam logic [7:0]  LFSR_SEED    = 8'h5_A;

  // phase offsets in twelfths of a period
  localparam int unsigned TWELFTHS = 12;
  localparam logic [3:0] PH_0   = 4'h0;
  localparam logic [3:0] PH_90  = 4'h3;
  localparam logic [3:0] PH_120 = 4'h4;
  localparam logic [3:0] PH_180 = 4'h6;
  localparam logic [3:0] PH_240 = 4'h8;
  localparam logic [1:0] NPH_THREE = 2'h1;
  localparam logic [1:0] NPH_FOUR  = 2'h2;

  // watchdog period, no figure printed
  localparam int unsigned WD_PERIOD_US = 40000;

endpackage

// >>> hdl/bcp_fault_filter.sv
// persistence filter that raises the output fault flag
module bcp_fault_filter (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        armed,
  input  wire logic        fault,
  input  wire logic [15:0] limit,
  input  wire logic        clr,
  output logic             flag
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        flag_reg;
  logic        hit;

  // count while the fault persists, restart when it drops
  assign hit      = armed && fault && (cnt_reg >= limit);
  assign cnt_next = (armed && fault && !hit) ? cnt_reg + 16'h0001 :
                    (armed && fault) ? cnt_reg : 16'h0000;
  assign flag     = flag_reg;

  // sticky flag, a new hit beats a clear
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cnt_reg  <= 16'h0000;
      flag_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      flag_reg <= hit | (flag_reg & ~clr);
    end
  end

endmodule

// >>> hdl/bcp_regs.sv
// boost clock, dither, phase and watchdog control registers
module bcp_regs #(
  parameter int unsigned FILT_CYC_0  = bcp_pkg::FILT_US_0 * bcp_pkg::CYC_PER_US,
  parameter int unsigned FILT_CYC_4  = bcp_pkg::FILT_US_4 * bcp_pkg::CYC_PER_US,
  parameter int unsigned FILT_CYC_5  = bcp_pkg::FILT_US_5 * bcp_pkg::CYC_PER_US,
  parameter int unsigned FILT_CYC_7  = bcp_pkg::FILT_US_7 * bcp_pkg::CYC_PER_US,
  parameter int unsigned MOD_CYC     = bcp_pkg::MOD_SLOW_CYC,
  parameter int unsigned WD_CYC      = bcp_pkg::WD_PERIOD_US * bcp_pkg::CYC_PER_US
) (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        FRAME_STB,
  input  wire logic        FRAME_WR,
  input  wire logic [5:0]  FRAME_ADDR,
  input  wire logic [23:0] FRAME_DATA,
  output logic [23:0]      RD_DATA,
  output logic             RD_VALID,
  output logic             PARITY_ERR,
  input  wire logic        MASTER_SLAVE_ROLE,
  input  wire logic        ACTIVE_MODE,
  input  wire logic        POWER_GOOD,
  input  wire logic        OUT_FAULT,
  input  wire logic        OUT_FAIL_CLR,
  output logic             OUT_FAIL_FLAG,
  input  wire logic        WATCHDOG_FAILURE_FLAG_CLR,
  output logic             WATCHDOG_FAILURE_FLAG,
  output logic             LIMP_HOME,
  input  wire logic        SYNC_I,
  output logic             SYNC_O,
  output logic             SYNC_OE,
  output logic             PHASE_ONE,
  output logic             PHASE_TWO
);

  bcp_pkg::bcp_cfg_s cfg_reg;
  bcp_pkg::bcp_cfg_s cfg_next;
  bcp_pkg::bcp_cfg_s wr_cfg;
  logic        wd_bit_reg;
  logic        unlock_reg;
  logic        parity_ok;
  logic        wr_ok;
  logic        wr_unlock;
  logic        wr_cfg_hit;
  logic        wr_wd_hit;
  logic [23:0] rd_word;
  logic [23:0] rd_raw;
  logic [23:0] rd_data_reg;
  logic        rd_valid_reg;
  logic        perr_reg;

  // pin synchronisers
  logic [1:0]  pg_sync;
  logic [1:0]  flt_sync;
  logic [1:0]  sy_sync;
  logic        pg_seen_reg;

  // frame checks and address decode
  assign parity_ok  = ^FRAME_DATA;
  assign wr_ok      = FRAME_STB && FRAME_WR && parity_ok;
  assign wr_cfg     = bcp_pkg::bcp_cfg_s'(FRAME_DATA);
  assign wr_unlock  = wr_ok && (FRAME_ADDR == bcp_pkg::ADDR_UNLOCK_REG) &&
                      FRAME_DATA[bcp_pkg::UNLOCK_BIT];
  assign wr_cfg_hit = wr_ok && (FRAME_ADDR == bcp_pkg::ADDR_CLK_PHASE);
  assign wr_wd_hit  = wr_ok && (FRAME_ADDR == bcp_pkg::ADDR_WDOG);

  // reserved codes fall back to defaults, disable bits need unlock to set
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_cfg_hit) begin
      cfg_next = wr_cfg;
      cfg_next.unused = 8'h00;
      cfg_next.parity = 1'b0;
      if (wr_cfg.output_fault_filter_time == bcp_pkg::CODE_RSVD) begin
        cfg_next.output_fault_filter_time = bcp_pkg::FILT_DEF;
      end
      if (wr_cfg.switching_freq_sel == bcp_pkg::CODE_RSVD) begin
        cfg_next.switching_freq_sel = bcp_pkg::FREQ_DEF;
      end
      // a clear always passes, a set needs the unlock frame just before
      cfg_next.phase_disable = wr_cfg.phase_disable &
                               (cfg_reg.phase_disable | {2{unlock_reg}});
    end
  end

  // read word with odd parity in bit 0
  assign rd_raw  = (FRAME_ADDR == bcp_pkg::ADDR_CLK_PHASE) ? 24'(cfg_reg) :
                   (FRAME_ADDR == bcp_pkg::ADDR_WDOG) ?
                   {wd_bit_reg, 23'h00_0000} : 24'h00_0000;
  assign rd_word = {rd_raw[23:1], ~(^rd_raw[23:1])};

  // register write, unlock tracking and read answer
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cfg_reg      <= '{unused: 8'h00, output_fault_filter_time: bcp_pkg::FILT_DEF,
                        dither_enable: 1'b0, dither_deviation_sel: bcp_pkg::FDEV_DEF,
                        dither_rate_sel: bcp_pkg::FMOD_DEF,
                        switching_freq_sel: bcp_pkg::FREQ_DEF,
                        phase_count_sel: bcp_pkg::NPH_DEF,
                        phase_disable: bcp_pkg::DIS_DEF, parity: 1'b0};
      wd_bit_reg   <= 1'b0;
      unlock_reg   <= 1'b0;
      rd_data_reg  <= 24'h00_0000;
      rd_valid_reg <= 1'b0;
      perr_reg     <= 1'b0;
    end else begin
      cfg_reg      <= cfg_next;
      if (wr_wd_hit) begin
        wd_bit_reg <= FRAME_DATA[bcp_pkg::WDOG_BIT];
      end
      // any frame, read or bad parity too, uses up the unlock
      if (FRAME_STB) begin
        unlock_reg <= wr_unlock;
      end
      rd_valid_reg <= FRAME_STB && !FRAME_WR && parity_ok;
      if (FRAME_STB && !FRAME_WR && parity_ok) begin
        rd_data_reg <= rd_word;
      end
      perr_reg     <= FRAME_STB && !parity_ok;
    end
  end

  assign RD_DATA    = rd_data_reg;
  assign RD_VALID   = rd_valid_reg;
  assign PARITY_ERR = perr_reg;

  // two flip-flops on the power good, output fault and sync inputs
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pg_sync     <= 2'b00;
      flt_sync    <= 2'b00;
      sy_sync     <= 2'b00;
      pg_seen_reg <= 1'b0;
    end else begin
      pg_sync     <= {pg_sync[0], POWER_GOOD};
      flt_sync    <= {flt_sync[0], OUT_FAULT};
      sy_sync     <= {sy_sync[0], SYNC_I};
      pg_seen_reg <= pg_seen_reg | pg_sync[1];
    end
  end

  // output fault filter time select
  logic [15:0] filt_limit;
  assign filt_limit =
    (cfg_reg.output_fault_filter_time == 3'h1) ? 16'(bcp_pkg::FILT_US_1 * bcp_pkg::CYC_PER_US) :
    (cfg_reg.output_fault_filter_time == 3'h2) ? 16'(bcp_pkg::FILT_US_2 * bcp_pkg::CYC_PER_US) :
    (cfg_reg.output_fault_filter_time == 3'h3) ? 16'(bcp_pkg::FILT_US_3 * bcp_pkg::CYC_PER_US) :
    (cfg_reg.output_fault_filter_time == 3'h4) ? 16'(FILT_CYC_4) :
    (cfg_reg.output_fault_filter_time == 3'h5) ? 16'(FILT_CYC_5) :
    (cfg_reg.output_fault_filter_time == 3'h7) ? 16'(FILT_CYC_7) :
    16'(FILT_CYC_0);

  bcp_fault_filter u_filter (
    .MCLK  (MCLK),
    .SRST  (SRST),
    .armed (pg_seen_reg),
    .fault (flt_sync[1]),
    .limit (filt_limit),
    .clr   (OUT_FAIL_CLR),
    .flag  (OUT_FAIL_FLAG)
  );

  // watchdog: toggle of the refresh bit restarts the timer
  logic [19:0] wd_cnt_reg;
  logic        watchdog_failure_flag_reg;
  logic        wd_refresh;
  logic        wd_expire;
  assign wd_refresh = wr_wd_hit && (FRAME_DATA[bcp_pkg::WDOG_BIT] != wd_bit_reg);
  assign wd_expire  = ACTIVE_MODE && !wd_refresh && (wd_cnt_reg >= 20'(WD_CYC - 1));

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wd_cnt_reg  <= 20'h0_0000;
      watchdog_failure_flag_reg <= 1'b0;
    end else begin
      // timer idles outside active mode and restarts after an expiry
      if (!ACTIVE_MODE || wd_refresh || wd_expire) begin
        wd_cnt_reg <= 20'h0_0000;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 20'h0_0001;
      end
      watchdog_failure_flag_reg <= wd_expire | (watchdog_failure_flag_reg & ~WATCHDOG_FAILURE_FLAG_CLR);
    end
  end

  assign WATCHDOG_FAILURE_FLAG = watchdog_failure_flag_reg;
  assign LIMP_HOME             = watchdog_failure_flag_reg;

  // base period and dither amplitude
  logic [7:0]  base_per;
  logic [7:0]  max_dev;
  logic [15:0] dev_prod;
  assign base_per =
    (cfg_reg.switching_freq_sel == 3'h0) ? bcp_pkg::PER_0 :
    (cfg_reg.switching_freq_sel == 3'h1) ? bcp_pkg::PER_1 :
    (cfg_reg.switching_freq_sel == 3'h2) ? bcp_pkg::PER_2 :
    (cfg_reg.switching_freq_sel == 3'h4) ? bcp_pkg::PER_4 :
    (cfg_reg.switching_freq_sel == 3'h5) ? bcp_pkg::PER_5 :
    (cfg_reg.switching_freq_sel == 3'h7) ? bcp_pkg::PER_7 :
    bcp_pkg::PER_3;
  assign dev_prod = 16'(base_per * 16'(bcp_pkg::DEV_STEP_PCT) *
                    (16'(cfg_reg.dither_deviation_sel) + 16'h0001));
  assign max_dev  = 8'(dev_prod / 16'(bcp_pkg::PCT_FULL));

  // random offset refreshed at the modulation rate
  logic [7:0]  lfsr_reg;
  logic [13:0] mod_cnt_reg;
  logic [13:0] mod_len;
  logic        mod_tick;
  logic [15:0] ofs_prod;
  logic [8:0]  dith_ofs;
  logic [8:0]  dith_ofs_reg;
  assign mod_len  = 14'(MOD_CYC >> cfg_reg.dither_rate_sel);
  assign mod_tick = (mod_cnt_reg >= mod_len - 14'h0001);
  assign ofs_prod = 16'(max_dev) * 16'(lfsr_reg);                    // full product width
  // offset spans minus the peak deviation to just under plus it
  assign dith_ofs = 9'(ofs_prod >> 7) - {1'b0, max_dev};

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      lfsr_reg     <= bcp_pkg::LFSR_SEED;
      mod_cnt_reg  <= 14'h0000;
      dith_ofs_reg <= 9'h000;
    end else begin
      mod_cnt_reg <= mod_tick ? 14'h0000 : mod_cnt_reg + 14'h0001;
      if (mod_tick) begin
        lfsr_reg     <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        dith_ofs_reg <= cfg_reg.dither_enable ? dith_ofs : 9'h000;
      end
    end
  end

  // switching clock counter, period latched at each wrap
  logic [7:0] per_reg;
  logic [7:0] cnt_reg;
  logic [7:0] per_next;
  assign per_next = cfg_reg.dither_enable ? 8'(9'(base_per) + dith_ofs_reg) : base_per;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      per_reg <= bcp_pkg::PER_3;
      cnt_reg <= 8'h00;
    end else if (cnt_reg >= per_reg - 8'h01) begin
      cnt_reg <= 8'h00;
      per_reg <= per_next;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // square wave delayed by k twelfths of the running period
  function automatic logic wave(input logic [7:0] cnt, input logic [7:0] per,
                                input logic [3:0] k);
    logic [11:0] off;
    logic [7:0]  pos;
    // widen before the product, eight bits would wrap
    off = (12'(per) * 12'(k)) / 12'(bcp_pkg::TWELFTHS);
    pos = (cnt >= off[7:0]) ? cnt - off[7:0] : 8'(cnt + per - off[7:0]);
    return pos < (per >> 1);
  endfunction

  // phase placement by role and phase count
  logic is_slave;
  logic m_one;
  logic m_two;
  logic m_sync;
  logic s_one;
  logic s_two;
  assign is_slave = MASTER_SLAVE_ROLE;
  assign m_one  = wave(cnt_reg, per_reg, bcp_pkg::PH_0);
  assign m_two  = (cfg_reg.phase_count_sel == bcp_pkg::NPH_THREE) ?
                  wave(cnt_reg, per_reg, bcp_pkg::PH_120) :
                  wave(cnt_reg, per_reg, bcp_pkg::PH_180);
  assign m_sync = (cfg_reg.phase_count_sel == bcp_pkg::NPH_THREE) ?
                  wave(cnt_reg, per_reg, bcp_pkg::PH_240) :
                  (cfg_reg.phase_count_sel == bcp_pkg::NPH_FOUR) ?
                  wave(cnt_reg, per_reg, bcp_pkg::PH_90) : m_one;
  assign s_one  = sy_sync[1];
  assign s_two  = (cfg_reg.phase_count_sel == bcp_pkg::NPH_THREE) ? 1'b0 : ~sy_sync[1];

  // registered drive outputs gated by the disable bits
  logic ph1_reg;
  logic ph2_reg;
  logic sync_reg;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ph1_reg  <= 1'b0;
      ph2_reg  <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      ph1_reg  <= (is_slave ? s_one : m_one) & ~cfg_reg.phase_disable[0];
      ph2_reg  <= (is_slave ? s_two : m_two) & ~cfg_reg.phase_disable[1];
      sync_reg <= m_sync & ~is_slave;
    end
  end

  // gate drive pins, sync pin driven only as master
  assign PHASE_ONE = ph1_reg;
  assign PHASE_TWO = ph2_reg;
  assign SYNC_O    = sync_reg;
  assign SYNC_OE   = ~is_slave;

endmodule

// >>> tb/bcp_regs_checker.sv
// port assertions for the clock, phase and watchdog registers
module bcp_regs_checker (
  input wire logic        MCLK,
  input wire logic        SRST,
  input wire logic        FRAME_STB,
  input wire logic        FRAME_WR,
  input wire logic [23:0] FRAME_DATA,
  input wire logic [23:0] RD_DATA,
  input wire logic        RD_VALID,
  input wire logic        PARITY_ERR,
  input wire logic        MASTER_SLAVE_ROLE,
  input wire logic        ACTIVE_MODE,
  input wire logic        POWER_GOOD,
  input wire logic        OUT_FAULT,
  input wire logic        OUT_FAIL_FLAG,
  input wire logic        WATCHDOG_FAILURE_FLAG,
  input wire logic        LIMP_HOME,
  input wire logic        SYNC_O,
  input wire logic        SYNC_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pg_seen_reg;
  // remembers power good seen since reset
  always_ff @(posedge MCLK) begin
    pg_seen_reg <= SRST ? 1'b0 : (pg_seen_reg | POWER_GOOD);
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  // frame kinds
  sequence s_good; FRAME_STB && (^FRAME_DATA); endsequence
  sequence s_bad; FRAME_STB && !(^FRAME_DATA); endsequence
  sequence s_read; FRAME_STB && !FRAME_WR && (^FRAME_DATA); endsequence
  // frame answers, read word, pin direction, watchdog and fault flags
  a_bad_parity: assert property (s_bad |=> PARITY_ERR && !RD_VALID)
    else $error("even parity frame not flagged");
  a_good_quiet: assert property (s_good |=> !PARITY_ERR)
    else $error("good frame flagged");
  a_read_answer: assert property (s_read |=> RD_VALID && (^RD_DATA))
    else $error("read answer missing or parity even");
  a_rd_hold: assert property (!RD_VALID |-> $stable(RD_DATA))
    else $error("read word changed without answer");
  a_sync_dir: assert property (SYNC_OE == !MASTER_SLAVE_ROLE)
    else $error("sync pin direction wrong");
  a_slave_quiet: assert property (MASTER_SLAVE_ROLE && $past(MASTER_SLAVE_ROLE) |-> !SYNC_O)
    else $error("sync output driven as slave");
  a_limp_follows: assert property (WATCHDOG_FAILURE_FLAG |-> ##[0:1] LIMP_HOME)
    else $error("limp home not entered");
  a_wd_active: assert property ($rose(WATCHDOG_FAILURE_FLAG) |-> $past(ACTIVE_MODE))
    else $error("watchdog failed outside active mode");
  a_fault_persist: assert property ($rose(OUT_FAIL_FLAG) |-> $past(OUT_FAULT, 10))
    else $error("fault flag without lasting fault");
  a_pg_first: assert property ($rose(OUT_FAIL_FLAG) |-> pg_seen_reg)
    else $error("fault flag before power good");
endmodule

bind bcp_regs bcp_regs_checker u_chk (.MCLK(MCLK), .SRST(SRST), .FRAME_STB(FRAME_STB),
  .FRAME_WR(FRAME_WR), .FRAME_DATA(FRAME_DATA), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .PARITY_ERR(PARITY_ERR), .MASTER_SLAVE_ROLE(MASTER_SLAVE_ROLE), .ACTIVE_MODE(ACTIVE_MODE),
  .POWER_GOOD(POWER_GOOD), .OUT_FAULT(OUT_FAULT), .OUT_FAIL_FLAG(OUT_FAIL_FLAG),
  .WATCHDOG_FAILURE_FLAG(WATCHDOG_FAILURE_FLAG), .LIMP_HOME(LIMP_HOME), .SYNC_O(SYNC_O),
  .SYNC_OE(SYNC_OE));

// >>> tb/bcp_host_model.sv
// host model that issues register frames with odd parity, or with even parity on request
module bcp_host_model (
  input  wire logic        mclk,
  input  wire logic [23:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        parity_err,
  output logic             stb,
  output logic             wr,
  output logic [5:0]       addr,
  output logic [23:0]      data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] rd;
  logic        rv;
  logic        pe;
  logic        wd_bit = 1'b0;
  initial begin
    stb = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    data = 24'h00_0000;
  end
  // one frame, answer taken half a cycle after the taking edge
  task automatic send(input logic w, input logic [5:0] a, input logic [23:0] p, input bit bad);
    @(negedge mclk);
    stb = 1'b1;
    wr = w;
    addr = a;
    data = {p[23:1], (~^p[23:1]) ^ bad};
    @(negedge mclk);
    stb = 1'b0;
    addr = ~addr; // released bus shows no stale frame
    data = ~data;
    rd = rd_data;
    rv = rd_valid;
    pe = parity_err;
  endtask
  // unlock frame ahead of a guarded write
  task automatic unlock();
    send(1'b1, bcp_pkg::ADDR_UNLOCK_REG, 24'h00_0002, 1'b0);
  endtask
  // watchdog write, toggled or repeated
  task automatic wd_kick(input bit tog);
    wd_bit ^= tog;
    send(1'b1, bcp_pkg::ADDR_WDOG, {wd_bit, 23'h00_0000}, 1'b0);
  endtask
endmodule

// >>> tb/bcp_regs_tb.sv
// self-checking bench for the clock, phase and watchdog registers
module bcp_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FC0 = 40, FC4 = 60, FC5 = 80, FC7 = 100;
  localparam int unsigned FQ[8] = '{bcp_pkg::FREQ_0, bcp_pkg::FREQ_1, bcp_pkg::FREQ_2,
    bcp_pkg::FREQ_3, bcp_pkg::FREQ_4, bcp_pkg::FREQ_5, bcp_pkg::FREQ_3, bcp_pkg::FREQ_7};
  logic mclk = 0, srst = 1, role = 0, act = 0, pg = 0, flt = 0, fclr = 0, wclr = 0;
  logic sync_i = 0, stb, wr, rdv, perr, off, wdf, limp, sync_o, sync_oe, p1, p2, s1, s2, an;
  logic [5:0]  addr;
  logic [23:0] data, rdd, cfg;
  int          n_fail = 0, total_checks = 0, cyc = 0, mn, mx, md;
  int          fcode[5] = '{0, 4, 5, 7, 6};
  int          flim[5] = '{FC0, FC4, FC5, FC7, FC0};
  bit          sync_run = 0;

  bcp_regs #(.FILT_CYC_0(FC0), .FILT_CYC_4(FC4), .FILT_CYC_5(FC5), .FILT_CYC_7(FC7),
    .MOD_CYC(64), .WD_CYC(200)) dut (.MCLK(mclk), .SRST(srst), .FRAME_STB(stb),
    .FRAME_WR(wr), .FRAME_ADDR(addr), .FRAME_DATA(data), .RD_DATA(rdd), .RD_VALID(rdv),
    .PARITY_ERR(perr), .MASTER_SLAVE_ROLE(role), .ACTIVE_MODE(act), .POWER_GOOD(pg),
    .OUT_FAULT(flt), .OUT_FAIL_CLR(fclr), .OUT_FAIL_FLAG(off), .WATCHDOG_FAILURE_FLAG_CLR(wclr),
    .WATCHDOG_FAILURE_FLAG(wdf), .LIMP_HOME(limp), .SYNC_I(sync_i), .SYNC_O(sync_o),
    .SYNC_OE(sync_oe), .PHASE_ONE(p1), .PHASE_TWO(p2));
  bcp_host_model host (.mclk(mclk), .rd_data(rdd), .rd_valid(rdv), .parity_err(perr),
    .stb(stb), .wr(wr), .addr(addr), .data(data));

  // clock, free sync input and hang guard
  always #25 mclk = ~mclk;
  always @(negedge mclk) if (sync_run && (cyc % 19 == 0)) sync_i = ~sync_i;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      stop_test();
    end
  end

  // compare, verdict and expectations
  task automatic chk_word(string nm, logic [23:0] e, logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    chk_word(nm, {23'h00_0000, e}, {23'h00_0000, g});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [23:0] exp_cfg(logic [23:0] old, logic [23:0] w, bit unl);
    logic [23:0] r;
    r = {8'h00, w[15:1], 1'b0};
    if (w[15:13] == 3'h6) r[15:13] = bcp_pkg::FILT_DEF;
    if (w[7:5] == 3'h6) r[7:5] = bcp_pkg::FREQ_DEF;
    if (!unl) r[2:1] = old[2:1] & w[2:1];
    r[0] = ~^r[23:1];
    return r;
  endfunction
  function automatic int exp_per(int c);
    return (bcp_pkg::CLK_HZ / 10) / FQ[c];
  endfunction
  function automatic logic [23:0] mk(logic [2:0] f, logic d, logic [1:0] v, logic [1:0] m,
                                     logic [2:0] q, logic [1:0] n, logic [1:0] s);
    return {8'h00, f, d, v, m, q, n, s, 1'b0};
  endfunction

  // frame tasks and phase observers
  task automatic rd_chk(logic [5:0] a, logic [23:0] e);
    host.send(1'b0, a, 24'h00_0000, 1'b0);
    chk_word("read word", e, host.rd);
    chk_bit("read valid", 1'b1, host.rv);
  endtask
  task automatic wcfg(logic [23:0] w, bit unl);
    if (unl) host.unlock();
    host.send(1'b1, bcp_pkg::ADDR_CLK_PHASE, w, 1'b0);
    cfg = exp_cfg(cfg, w, unl);
    rd_chk(bcp_pkg::ADDR_CLK_PHASE, cfg);
  endtask
  task automatic meas();
    int k, t, c;
    logic p;
    mn = 9999;
    mx = 0;
    k = 0;
    c = 0;
    p = p1;
    while (k < 10 && c < 4000) begin
      @(negedge mclk);
      c++;
      if (p1 === 1'b1 && p === 1'b0) begin
        if (k > 1) mn = (cyc - t < mn) ? cyc - t : mn;
        if (k > 1) mx = (cyc - t > mx) ? cyc - t : mx;
        t = cyc;
        k++;
      end
      p = p1;
    end
  endtask
  task automatic watch(int n);
    s1 = 0;
    s2 = 0;
    an = 1;
    repeat (n) begin
      @(negedge mclk);
      s1 |= p1;
      s2 |= p2;
      an &= (p2 === ~p1);
    end
  endtask
  // rise of phase two and sync out counted from a rise of phase one
  task automatic lag(int deg2, int degs);
    int c, c2, cs;
    logic q1, q2, qs;
    c = -1;
    c2 = -1;
    cs = -1;
    repeat (300) begin
      q1 = p1;
      q2 = p2;
      qs = sync_o;
      @(negedge mclk);
      if (c >= 0) c++;
      if (c < 0 && p1 === 1'b1 && q1 === 1'b0) c = 0;
      if (c >= 0 && c2 < 0 && p2 === 1'b1 && q2 === 1'b0) c2 = c;
      if (c >= 0 && cs < 0 && sync_o === 1'b1 && qs === 1'b0) cs = c;
    end
    chk_word("phase two lag", 24'(exp_per(3) * deg2 / 360), 24'(c2));
    chk_word("sync out lag", 24'(exp_per(3) * degs / 360), 24'(cs));
  endtask

  // main sequence
  initial begin
    cfg = 24'h00_0361;
    void'($urandom(50));
    repeat (3) @(negedge mclk);
    srst = 0;
    chk_bit("sync dir", 1'b1, sync_oe);
    rd_chk(bcp_pkg::ADDR_CLK_PHASE, 24'h00_0361);
    rd_chk(bcp_pkg::ADDR_WDOG, 24'h00_0001);
    rd_chk(6'h05, 24'h00_0001);
    host.send(1'b1, bcp_pkg::ADDR_CLK_PHASE, 24'h00_FFFE, 1'b1);
    chk_bit("parity err", 1'b1, host.pe);
    rd_chk(bcp_pkg::ADDR_CLK_PHASE, cfg);
    for (int d = 1; d < 3; d++) begin
      wcfg(mk(0, 0, 0, 3, 3, 0, 2'(d)), 1);
      watch(300);
      chk_bit("phase one runs", d[1], s1);
      chk_bit("phase two runs", d[0], s2);
    end
    wcfg(mk(0, 0, 0, 3, 3, 0, 0), 0);
    host.unlock();
    rd_chk(bcp_pkg::ADDR_CLK_PHASE, cfg);
    wcfg(mk(0, 0, 0, 3, 3, 0, 3), 0);
    wcfg(24'h00_C0C0, 0);
    repeat (20) wcfg(24'($urandom), 0);
    for (int c = 0; c < 8; c++) begin
      wcfg(mk(0, 0, 0, 3, 3'(c), 0, 0), 0);
      meas();
      chk_word("period max", 24'(exp_per(c)), 24'(mx));
      chk_word("period min", 24'(exp_per(c)), 24'(mn));
    end
    for (int v = 0; v < 4; v++) begin
      wcfg(mk(0, 1, 2'(v), 2'(v), 0, 0, 0), 0);
      meas();
      md = exp_per(0) * 5 * (v + 1) / 100;
      chk_bit("dither low", 1'b1, mn >= exp_per(0) - md);
      chk_bit("dither high", 1'b1, mx < exp_per(0) + md);
      chk_bit("dither moves", 1'b1, mn != mx);
    end
    role = 1;
    sync_run = 1;
    wcfg(mk(0, 0, 0, 3, 3, 0, 0), 0);
    watch(400);
    chk_bit("slave inverse", 1'b1, an);
    chk_bit("slave follows", 1'b1, s1);
    chk_bit("sync out", 1'b0, sync_o | sync_oe);
    wcfg(mk(0, 0, 0, 3, 3, 1, 0), 0);
    watch(400);
    chk_bit("slave phase two", 1'b0, s2);
    role = 0;
    sync_run = 0;
    for (int n = 0; n < 3; n++) begin
      wcfg(mk(0, 0, 0, 3, 3, 2'(n), 0), 0);
      lag((n == 1) ? 120 : 180, (n == 1) ? 240 : (n == 2) ? 90 : 0);
    end
    flt = 1;
    repeat (300) @(negedge mclk);
    chk_bit("fault before pg", 1'b0, off);
    flt = 0;
    pg = 1;
    for (int i = 0; i < 5; i++) begin
      wcfg(mk(3'(fcode[i]), 0, 0, 3, 3, 0, 0), 0);
      flt = 1;
      repeat (flim[i] - 5) @(negedge mclk);
      chk_bit("fault early", 1'b0, off);
      repeat (15) @(negedge mclk);
      chk_bit("fault set", 1'b1, off);
      flt = 0;
      repeat (4) @(negedge mclk);
      fclr = 1;
      @(negedge mclk);
      fclr = 0;
      @(negedge mclk);
      chk_bit("fault cleared", 1'b0, off);
    end
    act = 1;
    repeat (4) begin
      repeat (150) @(negedge mclk);
      host.wd_kick(1'b1);
    end
    chk_bit("wd quiet", 1'b0, wdf);
    rd_chk(bcp_pkg::ADDR_WDOG, {host.wd_bit, 22'h00_0000, ~host.wd_bit});
    repeat (3) begin
      repeat (100) @(negedge mclk);
      host.wd_kick(1'b0);
    end
    chk_bit("watchdog_failure_flag", 1'b1, wdf);
    chk_bit("limp home", 1'b1, limp);
    act = 0;
    wclr = 1;
    @(negedge mclk);
    wclr = 0;
    repeat (400) @(negedge mclk);
    chk_bit("wd idle", 1'b0, wdf);
    stop_test();
  end
endmodule
